/* File: dv/hvse_top_tb.sv */
/*
  Self-checking bench for the valve speed encoder with the valve block model.
  Assumes the package constants and a 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hvse_top_tb;
  import hvse_pkg::*;
  logic        sys_clk;
  logic        rst;
  logic [2:0]  speed_cmd;
  logic        dir_down;
  logic [2:0]  variant_sel;
  logic        slow;
  wire         fb_pin;
  logic [7:0]  valve_out;
  logic        run_feedback_state;
  logic        bypass_pending;
  int          n_mismatch;
  int          cmp_count;
  logic [23:0] r;
  // Rows: variant, speed, outputs going up, outputs going down
  logic [23:0] rows [27] = '{24'h114080, 24'h124484, 24'h144484, 24'h154484,
    24'h164080, 24'h214080, 24'h2250A0, 24'h2458A8, 24'h2558A8, 24'h264080,
    24'h314181, 24'h324585, 24'h334989, 24'h345090, 24'h355090, 24'h364080,
    24'h414080, 24'h42588C, 24'h435090, 24'h444888, 24'h454888, 24'h4660A0,
    24'h514080, 24'h5250A0, 24'h5450A0, 24'h5550A0, 24'h564080};

  hvse_top DUT (.sys_clk(sys_clk), .rst(rst), .speed_cmd(speed_cmd),
    .dir_down(dir_down), .variant_sel(variant_sel),
    .unintended_motion_run_feedback(fb_pin), .valve_out(valve_out),
    .run_feedback_state(run_feedback_state), .bypass_pending(bypass_pending));

  hvse_valve_model u_valve (.sys_clk(sys_clk), .rst(rst), .valve_out(valve_out),
    .slow(slow), .unintended_motion_run_feedback(fb_pin));

  // Clock generation
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Compare at the falling edge, where outputs are settled
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task complete_run;
    $display("mismatches %0d of %0d comparisons", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Apply a command at a rising edge and wait
  task cmd(input logic [2:0] v, input logic [2:0] s, input logic d, input int n);
    @(posedge sys_clk);
    variant_sel <= v;
    speed_cmd   <= s;
    dir_down    <= d;
    slow        <= d;
    cyc(n);
    @(negedge sys_clk);
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    speed_cmd = 3'h0;
    dir_down = 1'b0;
    variant_sel = 3'h1;
    slow = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    cyc(2);
    @(negedge sys_clk);
    chk("valve_out", 8'h00, valve_out);
    @(posedge sys_clk);
    rst <= 1'b0;
    cyc(2);
    for (int i = 0; i < 27; i++)
    begin
      r = rows[i];
      for (int d = 0; d < 2; d++)
      begin
        cmd(r[22:20], 3'h0, 1'b0, 2);
        cmd(r[22:20], r[18:16], d[0], 10);
        chk("valve_out", d ? r[7:0] : r[15:8], valve_out);
        chk("run_fb", {7'h0, r[22:20] inside {3'h3, 3'h4}}, {7'h0, run_feedback_state});
        cmd(r[22:20], 3'h0, 1'b0, 3);
        chk("valve_out", 8'h00, valve_out);
      end
    end
    // Direction reversed with no idle between
    cmd(3'h1, 3'h2, 1'b0, 3);
    cmd(3'h1, 3'h2, 1'b1, 2);
    chk("valve_out", 8'h84, valve_out);
    cmd(3'h1, 3'h7, 1'b1, 3);
    chk("valve_out", 8'h00, valve_out);
    cmd(3'h0, 3'h2, 1'b0, 3);
    chk("valve_out", 8'h00, valve_out);
    cmd(3'h0, 3'h0, 1'b0, 2);
    // Bypass lead, after-run, restart and reset in the after-run
    for (int v = 6; v < 8; v++)
    begin
      cmd(v[2:0], 3'h4, 1'b1, 2);
      chk("valve_out", 8'h10, valve_out);
      cyc(900);
      @(negedge sys_clk);
      chk("valve_out", 8'h10, valve_out);
      cmd(v[2:0], 3'h0, 1'b1, 3);
      chk("valve_out", 8'h10, valve_out);
      chk("pending", 8'h01, {7'h0, bypass_pending});
      cmd(v[2:0], 3'h2, 1'b0, 3);
      chk("valve_out", 8'h10, valve_out);
      cmd(v[2:0], 3'h0, 1'b0, 3);
      @(posedge sys_clk);
      rst <= 1'b1;
      @(negedge sys_clk);
      chk("valve_out", 8'h00, valve_out);
      chk("pending", 8'h00, {7'h0, bypass_pending});
      cyc(2);
      rst <= 1'b0;
      cyc(2);
    end
    complete_run();
  end
endmodule
`default_nettype wire

/* File: dv/hvse_valve_model.sv */
/*
  Behavioural model of the hydraulic valve block on the far side of the encoder.
  Assumes it shares sys_clk and rst with the encoder under test.
*/
`timescale 1ns/1ps
`default_nettype none
module hvse_valve_model
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Valve drive from the encoder
  input  wire logic [7:0] valve_out,
  input  wire logic       slow,
  // Run feedback to the encoder
  output logic            unintended_motion_run_feedback
);
  logic [3:0] run_cnt_r;
  logic [3:0] run_cnt_nxt;

  // Count how long a travel valve has been open
  always_comb
  begin
    run_cnt_nxt = 4'h0;
    if (valve_out[7] | valve_out[6])
      run_cnt_nxt = (run_cnt_r == 4'hF) ? run_cnt_r : run_cnt_r + 4'h1;
  end

  // Register the count
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      run_cnt_r <= 4'h0;
    else
      run_cnt_r <= run_cnt_nxt;
  end

  // Report motion once the valve has had time to open, late in slow mode
  assign unintended_motion_run_feedback = (run_cnt_r > (slow ? 4'h4 : 4'h1));
endmodule
`default_nettype wire

/* File: hw/hvse_pkg.sv */
/*
  Constants and types for the hydraulic valve speed encoder.
  Assumes a 250 MHz system clock and a static variant selection.
*/
// Operation
// - Variant 1: travel valve 7/8 always; output 3 at first, inspection, rescue.
// - Variant 2: direction only at creep/relevel; 5/6 at first/inspection/rescue; plus 4 inspection/rescue.
// - Variant 3: creep dir+1; first +3+1; second +4+1; insp/rescue +5; relevel dir.
// - Variant 4: creep dir; first 7,5,4 or 8,4,3; second +5; insp +4; relevel +6.
// - Variant 5: travel valve 7/8; first, inspection, rescue add 5 up or 6 down.
// - Variant 6: output 5 every run, 8 downward, 3 at first/inspection/rescue.
// - Variant 7: as variant 6 but inspection/rescue use output 4 instead of 3.
// - Variants 6 and 7: output 5 leads all other outputs by 300 ms.
// - Variants 6 and 7: output 5 stays on 1.5 s after stop.
// - Variants 3 and 4: run feedback input is synchronised and supervised.
package hvse_pkg;
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000;
  localparam int unsigned PRE_MS        = 300;
  localparam int unsigned AFTER_MS      = 1500;
  localparam logic [7:0]  OUT_RESET     = 8'h00;
  // Output bit positions (output n at bit n-1)
  localparam int unsigned O1 = 0;
  localparam int unsigned O3 = 2;
  localparam int unsigned O4 = 3;
  localparam int unsigned O5 = 4;
  localparam int unsigned O6 = 5;
  localparam int unsigned O7 = 6;
  localparam int unsigned O8 = 7;

  typedef enum logic [2:0]
  {
    SPD_NONE   = 3'h0,
    CREEP      = 3'h1,
    FIRST      = 3'h2,
    SECOND     = 3'h3,
    INSPECTION = 3'h4,
    RESCUE     = 3'h5,
    RELEVEL    = 3'h6
  } hvse_speed_type;

  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'h1,
    ST_PRE   = 4'h2,
    ST_RUN   = 4'h4,
    ST_AFTER = 4'h8
  } hvse_state_type;
endpackage

/* File: hw/hvse_tick_gen.sv */
/*
  Millisecond tick divider.
  Assumes sys_clk at the package rate.
*/
`timescale 1ns/1ps
`default_nettype none
module hvse_tick_gen
  import hvse_pkg::*;
(
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  rst,
  // Tick out
  hvse_tick_if.src   tk
);
  logic [17:0] cnt_r;
  logic [17:0] cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;

  // Wrap counter, pulse one cycle per millisecond
  always_comb
  begin
    tick_nxt = (cnt_r == 18'(TICK_CYCLES - 1));
    cnt_nxt  = tick_nxt ? 18'h00000 : cnt_r + 18'h00001;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r  <= 18'h00000;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tk.ms_tick = tick_r;

  tick_period_a: assert property (@(posedge sys_clk) disable iff (rst)
    tick_r |=> !tick_r [*8])
    else $error("ms tick repeated too soon");
endmodule
`default_nettype wire

/* File: hw/hvse_tick_if.sv */
/*
  Interface carrying the millisecond tick between the encoder and its divider.
  Assumes both ends share sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface hvse_tick_if;
  logic ms_tick;
  modport src (output ms_tick);
  modport dst (input  ms_tick);
endinterface
`default_nettype wire

/* File: hw/hvse_top.sv */
/*
  Hydraulic valve speed encoder: maps speed and direction to valve outputs 1..8.
  Assumes speed, direction and variant come from logic on sys_clk; the
  run feedback pin comes from outside and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module hvse_top
  import hvse_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Run command
  input  wire logic [2:0] speed_cmd,
  input  wire logic       dir_down,
  input  wire logic [2:0] variant_sel,
  // Valve unit feedback pin
  input  wire logic       unintended_motion_run_feedback,
  // Valve outputs, output n at bit n-1
  output logic      [7:0] valve_out,
  output logic            run_feedback_state,
  output logic            bypass_pending
);
  hvse_tick_if tk ();

  hvse_tick_gen u_tick
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tk      (tk)
  );

  logic           fb_s1_r;
  logic           fb_s2_r;
  logic           fb_out_r;
  logic           fb_out_nxt;
  hvse_state_type st_r;
  hvse_state_type st_nxt;
  logic [10:0]    ms_r;
  logic [10:0]    ms_nxt;
  logic [7:0]     map;
  logic [7:0]     out_nxt;
  logic [7:0]     out_r;
  logic           run;
  logic           timed;
  logic           pend_r;
  logic           pend_nxt;

  assign run   = (speed_cmd != 3'(SPD_NONE)) && (speed_cmd <= 3'(RELEVEL));
  assign timed = (variant_sel == 3'h6) || (variant_sel == 3'h7);

  // Speed and direction to valve map per variant
  always_comb
  begin
    map = 8'h00;
    if (run)
    begin
      case (variant_sel)
        3'h1:
        begin
          map[dir_down ? O8 : O7] = 1'b1;
          if (speed_cmd == FIRST || speed_cmd == INSPECTION || speed_cmd == RESCUE)
            map[O3] = 1'b1;
        end
        3'h2:
        begin
          map[dir_down ? O8 : O7] = 1'b1;
          if (speed_cmd == FIRST || speed_cmd == INSPECTION || speed_cmd == RESCUE)
            map[dir_down ? O6 : O5] = 1'b1;
          if (speed_cmd == INSPECTION || speed_cmd == RESCUE)
            map[O4] = 1'b1;
        end
        3'h3:
        begin
          map[dir_down ? O8 : O7] = 1'b1;
          if (speed_cmd == CREEP || speed_cmd == FIRST || speed_cmd == SECOND)
            map[O1] = 1'b1;
          if (speed_cmd == FIRST)
            map[O3] = 1'b1;
          if (speed_cmd == SECOND)
            map[O4] = 1'b1;
          if (speed_cmd == INSPECTION || speed_cmd == RESCUE)
            map[O5] = 1'b1;
        end
        3'h4:
        begin
          map[dir_down ? O8 : O7] = 1'b1;
          case (speed_cmd)
            FIRST:
            begin
              map[O4] = 1'b1;
              map[dir_down ? O3 : O5] = 1'b1;
            end
            SECOND:     map[O5] = 1'b1;
            INSPECTION: map[O4] = 1'b1;
            RESCUE:     map[O4] = 1'b1;
            RELEVEL:    map[O6] = 1'b1;
            default:    map[O1] = 1'b0;
          endcase
        end
        3'h5:
        begin
          map[dir_down ? O8 : O7] = 1'b1;
          if (speed_cmd == FIRST || speed_cmd == INSPECTION || speed_cmd == RESCUE)
            map[dir_down ? O6 : O5] = 1'b1;
        end
        3'h6, 3'h7:
        begin
          map[O5] = 1'b1;
          map[O8] = dir_down;
          if (speed_cmd == FIRST)
            map[O3] = 1'b1;
          if (speed_cmd == INSPECTION || speed_cmd == RESCUE)
          begin
            if (variant_sel == 3'h7)
              map[O4] = 1'b1;
            else
              map[O3] = 1'b1;
          end
        end
        default: map = 8'h00;
      endcase
    end
  end

  // Run sequencer with bypass lead and after-run
  always_comb
  begin
    st_nxt  = st_r;
    ms_nxt  = ms_r;
    out_nxt = OUT_RESET;
    case (st_r)
      ST_IDLE:
      begin
        ms_nxt = 11'h000;
        if (run && timed)
          st_nxt = ST_PRE;
        else if (run)
          out_nxt = map;
      end
      ST_PRE:
      begin
        out_nxt[O5] = 1'b1;
        if (!run)
        begin
          st_nxt = ST_AFTER;
          ms_nxt = 11'h000;
        end
        else if (tk.ms_tick)
        begin
          if (ms_r == 11'(PRE_MS - 1))
          begin
            st_nxt = ST_RUN;
            ms_nxt = 11'h000;
          end
          else
            ms_nxt = ms_r + 11'h001;
        end
      end
      ST_RUN:
      begin
        out_nxt = map;
        out_nxt[O5] = 1'b1;
        if (!run)
        begin
          st_nxt = ST_AFTER;
          out_nxt = 8'h10;
          ms_nxt = 11'h000;
        end
      end
      ST_AFTER:
      begin
        out_nxt[O5] = 1'b1;
        if (run && timed)
        begin
          st_nxt = ST_PRE;
          ms_nxt = 11'h000;
        end
        else if (tk.ms_tick)
        begin
          if (ms_r == 11'(AFTER_MS - 1))
          begin
            st_nxt = ST_IDLE;
            out_nxt = OUT_RESET;
          end
          else
            ms_nxt = ms_r + 11'h001;
        end
      end
      default:
      begin
        st_nxt = ST_IDLE;
        ms_nxt = 11'h000;
      end
    endcase
    fb_out_nxt = fb_s2_r && ((variant_sel == 3'h3) || (variant_sel == 3'h4));
    pend_nxt   = out_nxt[O5] && (st_nxt == ST_AFTER);
  end

  // Registers; feedback pin passes two flip-flops first
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r     <= ST_IDLE;
      ms_r     <= 11'h000;
      out_r    <= OUT_RESET;
      fb_s1_r  <= 1'b0;
      fb_s2_r  <= 1'b0;
      fb_out_r <= 1'b0;
      pend_r   <= 1'b0;
    end
    else
    begin
      st_r     <= st_nxt;
      ms_r     <= ms_nxt;
      out_r    <= out_nxt;
      fb_s1_r  <= unintended_motion_run_feedback;
      fb_s2_r  <= fb_s1_r;
      fb_out_r <= fb_out_nxt;
      pend_r   <= pend_nxt;
    end
  end

  assign valve_out          = out_r;
  assign run_feedback_state = fb_out_r;
  assign bypass_pending     = pend_r;

  // Sequencer timing checks
  pre_lead_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_PRE) |-> (out_nxt == 8'h10))
    else $error("bypass lead has other outputs");
  pre_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_PRE && st_nxt == ST_RUN) |-> (ms_r == 11'(PRE_MS - 1)))
    else $error("bypass lead wrong length");
  run_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_RUN) |-> valve_out[O5])
    else $error("bypass off during run");
  after_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_AFTER && st_nxt == ST_IDLE) |-> (ms_r == 11'(AFTER_MS - 1)))
    else $error("after-run wrong length");
  after_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_AFTER && st_nxt != ST_IDLE) |=> valve_out[O5])
    else $error("bypass dropped in after-run");
  after_pend_a: assert property (@(posedge sys_clk) disable iff (rst)
    bypass_pending |-> (valve_out == 8'h10))
    else $error("after-run drives other outputs");
  idle_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_IDLE && !run) |=> (valve_out == 8'h00))
    else $error("outputs on while idle");
  untimed_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_IDLE && !timed) |=> (st_r == ST_IDLE))
    else $error("untimed variant left idle");
  // Mapping checks per variant
  v1_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    (variant_sel == 3'h1 && speed_cmd == 3'(FIRST) && !dir_down && st_r == ST_IDLE)
    |=> (valve_out == 8'h44))
    else $error("variant 1 first speed map");
  v2_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    (variant_sel == 3'h2 && speed_cmd == 3'(INSPECTION) && dir_down && st_r == ST_IDLE)
    |=> (valve_out == 8'hA8))
    else $error("variant 2 inspection down map");
  v3_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    (variant_sel == 3'h3 && speed_cmd == 3'(SECOND) && !dir_down && st_r == ST_IDLE)
    |=> (valve_out == 8'h49))
    else $error("variant 3 second up map");
  v4_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    (variant_sel == 3'h4 && speed_cmd == 3'(FIRST) && dir_down && st_r == ST_IDLE)
    |=> (valve_out == 8'h8C))
    else $error("variant 4 first down map");
  v5_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    (variant_sel == 3'h5 && speed_cmd == 3'(RESCUE) && dir_down && st_r == ST_IDLE)
    |=> (valve_out == 8'hA0))
    else $error("variant 5 rescue down map");
  v6_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_RUN && variant_sel == 3'h6 && speed_cmd == 3'(FIRST) && dir_down)
    |=> (valve_out == 8'h94))
    else $error("variant 6 first down map");
  v6_up_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_RUN && timed && run && !dir_down)
    |=> (!valve_out[O7] && !valve_out[O8]))
    else $error("travel valve on in upward run");
  v7_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_RUN && variant_sel == 3'h7 && speed_cmd == 3'(INSPECTION) && run)
    |=> (valve_out[O4] && !valve_out[O3]))
    else $error("variant 7 inspection map");
  // Feedback supervision
  fb_sync_a: assert property (@(posedge sys_clk) disable iff (rst)
    (variant_sel == 3'h3) [*4] |-> (run_feedback_state == $past(fb_s2_r)))
    else $error("feedback state mismatch");
  fb_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    (variant_sel != 3'h3 && variant_sel != 3'h4) |=> !run_feedback_state)
    else $error("feedback state outside variants 3 and 4");
  lead_start_c: cover property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_IDLE) ##1 (st_r == ST_PRE));
  timed_run_c: cover property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_PRE) ##1 (st_r == ST_RUN));
  after_done_c: cover property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_AFTER) ##1 (st_r == ST_IDLE));
  rerun_c: cover property (@(posedge sys_clk) disable iff (rst)
    (st_r == ST_AFTER) ##1 (st_r == ST_PRE));
endmodule
`default_nettype wire
